// ---- rtl/modem_ctrl_defines.vh ----
// constants for the modem data-mode controller
// assumes a 25 MHz clock and byte-wide received/transmitted characters
`ifndef MODEM_CTRL_DEFINES_VH
`define MODEM_CTRL_DEFINES_VH
`define CLK_HZ          25000000
`define GUARD_MS        1000
`define GUARD_CYCLES    ((`CLK_HZ / 1000) * `GUARD_MS)
`define HANGUP_MS       20000
`define HANGUP_CYCLES   ((`CLK_HZ / 1000) * `HANGUP_MS)
`define CH_PLUS         8'h2b
`define CH_CR           8'h0d
`define CH_LF           8'h0a
`define RSP_OK          3'h0
`define RSP_CONNECT     3'h1
`define RSP_ERROR       3'h2
`define CMD_NONE        3'h0
`define CMD_DATA        3'h1
`define CMD_DIAL        3'h2
`define CMD_ONLINE      3'h3
`define CMD_HANGUP      3'h4
`define CMD_OTHER       3'h5
`endif

// ---- rtl/modem_data_ctrl.v ----
// command/data-mode controller of a cellular modem behind a UART
// assumes: rx bytes arrive as valid pulses; a command decoder classifies
// finished AT lines into cmd codes; responses go out as codes to a framer
// Summary of operation
// RULE1 - host waits for registration report before opening a session
// RULE2 - activation command for PPP on a context answers CONNECT
// RULE3 - host uses context 1, or 3 on one operator network
// RULE4 - host may query context definitions first
// RULE5 - host may set an access point name before activation
// RULE6 - packet dial string on context 1 also answers CONNECT
// RULE7 - after CONNECT, enter data mode and ignore AT commands
// RULE8 - in data mode every received character is payload
// RULE9 - in data mode unsolicited results are withheld from the UART
// RULE10 - unsolicited result in data mode toggles the ring indicator
// RULE11 - host escapes on ring toggle before reading the result
// RULE12 - escape plus-plus-plus needs one second idle before and after
// RULE13 - valid escape leaves data mode, answers OK, session suspended
// RULE14 - return-to-online command answers CONNECT, resumes data mode
// RULE15 - host escapes then hangs up to end the session
// RULE16 - hang-up answers OK within 20 seconds
// RULE17 - unguarded plus characters are payload and keep data mode
`timescale 1ns/1ns
`include "modem_ctrl_defines.vh"
module modem_data_ctrl #(
    parameter GUARD_CYCLES  = `GUARD_CYCLES,
    parameter HANGUP_CYCLES = `HANGUP_CYCLES
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // received uart characters
    input  wire [7:0] rx_byte,
    input  wire       rx_valid,
    // decoded command line (command mode only)
    input  wire [2:0] cmd_code,
    input  wire       cmd_valid,
    input  wire       hangup_done,
    // unsolicited results from the network side
    input  wire       urc_event,
    // payload toward the ppp engine
    output reg  [7:0] payload_data,
    output reg        payload_valid,
    input  wire       payload_ready,
    // responses toward the uart framer
    output reg  [2:0] rsp_code,
    output reg        rsp_valid,
    output reg        urc_send,
    // status
    output reg        data_mode,
    output reg        session_open,
    output reg        urc_ring_indicator,
    output reg        rx_ready
);
    // command mode, data mode (session online), waiting for hang-up
    localparam ST_CMD  = 2'h0;
    localparam ST_DATA = 2'h1;
    localparam ST_HANG = 2'h2;

    reg [1:0]  state;
    // guard timer, escape tracking and hang-up timer
    reg [31:0] idle_cnt;
    reg [1:0]  plus_cnt;
    reg        guard_ok;
    reg [31:0] hang_cnt;
    reg        urc_pend;
    // two-entry buffer for payload
    reg [7:0]  buf_data [0:1];
    reg        wr_ptr;
    reg        rd_ptr;
    reg [1:0]  count;

    wire idle_done = (idle_cnt >= GUARD_CYCLES - 1);
    wire buf_full  = (count == 2'h2);
    wire push      = rx_valid && (state == ST_DATA) && !buf_full;
    wire pop       = payload_valid && payload_ready;
    // a connect answered now must not be trailed by a result on the line
    wire       enter_data = cmd_valid && (state == ST_CMD) &&
                            (cmd_code == `CMD_DATA ||
                             cmd_code == `CMD_DIAL ||
                             (cmd_code == `CMD_ONLINE && session_open));

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_CMD;
            idle_cnt <= 32'h0;
            plus_cnt <= 2'h0;
            guard_ok <= 1'b0;
            hang_cnt <= 32'h0;
            urc_pend <= 1'b0;
            rsp_code <= 3'h0;
            rsp_valid <= 1'b0;
            urc_send <= 1'b0;
            data_mode <= 1'b0;
            session_open <= 1'b0;
            urc_ring_indicator <= 1'b0;
        end else begin
            // answer and result strobes are single-cycle pulses
            rsp_valid <= 1'b0;
            urc_send <= 1'b0;
            // line silence, saturating once a full guard time has passed;
            // counted in every state so the leading guard may span entry
            if (rx_valid)
                idle_cnt <= 32'h0;
            else if (!idle_done)
                idle_cnt <= idle_cnt + 32'h1;
            case (state)
            ST_CMD: begin
                if (urc_event || urc_pend) begin
                    if (enter_data) begin
                        urc_pend <= 1'b1;                     // [RULE9]
                    end else begin
                        urc_send <= 1'b1;
                        urc_pend <= 1'b0;
                    end
                end
                if (cmd_valid) begin
                    rsp_valid <= 1'b1;
                    case (cmd_code)
                    // context activation and packet dial both open it
                    `CMD_DATA, `CMD_DIAL: begin
                        rsp_code <= `RSP_CONNECT;            // [RULE2] [RULE6]
                        state <= ST_DATA;                     // [RULE7]
                        data_mode <= 1'b1;
                        session_open <= 1'b1;
                    end
                    `CMD_ONLINE: begin
                        // resume only a suspended session
                        if (session_open) begin
                            rsp_code <= `RSP_CONNECT;         // [RULE14]
                            state <= ST_DATA;
                            data_mode <= 1'b1;
                        end else begin
                            rsp_code <= `RSP_ERROR;
                        end
                    end
                    `CMD_HANGUP: begin
                        // no answer until the far side is done or time runs
                        rsp_valid <= 1'b0;
                        hang_cnt <= 32'h0;
                        state <= ST_HANG;
                    end
                    default: rsp_code <= `RSP_OK;
                    endcase
                end
            end
            ST_DATA: begin
                // results are held back and flagged on the ring line
                if (urc_event) begin
                    urc_pend <= 1'b1;                         // [RULE9]
                    urc_ring_indicator <= ~urc_ring_indicator; // [RULE10]
                end
                // a plus counts toward an escape only after a full
                // leading guard; any other byte restarts the count
                if (rx_valid) begin
                    if (rx_byte == `CH_PLUS &&
                        (plus_cnt != 2'h0 || idle_done)) begin
                        plus_cnt <= plus_cnt + 2'h1;          // [RULE12]
                        guard_ok <= (plus_cnt == 2'h2);
                    end else begin
                        plus_cnt <= 2'h0;                     // [RULE17]
                        guard_ok <= 1'b0;
                    end
                end else if (guard_ok && idle_done) begin
                    // three guarded plus bytes and a silent trailing guard
                    guard_ok <= 1'b0;                         // [RULE12]
                    plus_cnt <= 2'h0;
                    rsp_code <= `RSP_OK;                      // [RULE13]
                    rsp_valid <= 1'b1;
                    state <= ST_CMD;
                    data_mode <= 1'b0;
                end
            end
            ST_HANG: begin
                hang_cnt <= hang_cnt + 32'h1;
                // results during the hang-up wait go out afterwards
                if (urc_event)
                    urc_pend <= 1'b1;
                // the far side may finish early, else the limit answers
                if (hangup_done || hang_cnt >= HANGUP_CYCLES - 1) begin
                    rsp_code <= `RSP_OK;                      // [RULE16]
                    rsp_valid <= 1'b1;
                    session_open <= 1'b0;
                    state <= ST_CMD;
                end
            end
            default: state <= ST_CMD;
            endcase
        end
    end

    // payload buffer; plus bytes are forwarded too, an escape only
    // takes effect after the trailing guard time
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            payload_valid <= 1'b0;
            payload_data <= 8'h0;
            rx_ready <= 1'b1;
            buf_data[0] <= 8'h0;
            buf_data[1] <= 8'h0;
        end else begin
            if (push) begin
                buf_data[wr_ptr] <= rx_byte;                  // [RULE8]
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            // occupancy follows push and pop of the same cycle
            count <= count + {1'b0, push} - {1'b0, pop};
            // refill the output stage from the next entry on a pop
            if (!payload_valid || pop) begin
                if (count - {1'b0, pop} != 2'h0) begin
                    payload_valid <= 1'b1;
                    payload_data <= buf_data[pop ? ~rd_ptr : rd_ptr];
                end else begin
                    payload_valid <= 1'b0;
                end
            end
            // ready drops while both entries are taken; bytes are refused
            rx_ready <= (count + {1'b0, push} - {1'b0, pop}) != 2'h2;
        end
    end
endmodule // modem_data_ctrl

// ---- dv/modem_props_properties.sv ----
// checker: port properties of the data-mode controller
// assumes it is bound onto modem_data_ctrl, one clock domain
`timescale 1ns/1ns
`include "modem_ctrl_defines.vh"
module modem_props (
    input logic       clk, rst_n, rx_valid, rx_ready, cmd_valid,
    input logic       urc_event, rsp_valid, urc_send, data_mode,
    input logic       session_open, urc_ring_indicator, payload_valid,
    input logic [2:0] cmd_code, rsp_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire cmd_in = cmd_valid && !data_mode;
    a_data_connect: assert property (cmd_in && !session_open
        && cmd_code == `CMD_DATA |=> rsp_valid
        && rsp_code == `RSP_CONNECT && data_mode) else $error("no connect");
    a_dial_connect: assert property (cmd_in && !session_open
        && cmd_code == `CMD_DIAL |=> rsp_valid
        && rsp_code == `RSP_CONNECT && data_mode) else $error("no dial");
    a_cmd_ignored: assert property (data_mode && cmd_valid
        |=> !rsp_valid) else $error("command answered in data mode");
    a_urc_held: assert property (data_mode |-> !urc_send)
        else $error("result sent in data mode");
    a_ring_toggle: assert property (data_mode && urc_event
        |=> $changed(urc_ring_indicator)) else $error("ring not toggled");
    a_rx_payload: assert property (data_mode && rx_valid && rx_ready
        |-> ##2 payload_valid) else $error("byte not forwarded");
    a_plus_keeps: assert property (data_mode && rx_valid
        |=> data_mode) else $error("data mode left on a byte");
    a_escape_ok: assert property ($fell(data_mode)
        |-> ##[0:1] rsp_valid && rsp_code == `RSP_OK) else $error("no ok");
    a_online_rsp: assert property (cmd_in && cmd_code == `CMD_ONLINE
        |=> rsp_valid && rsp_code == ($past(session_open) ?
        `RSP_CONNECT : `RSP_ERROR)) else $error("bad online answer");
    cover property (rsp_valid && rsp_code == `RSP_CONNECT);
    cover property ($fell(data_mode));
    cover property (payload_valid && !rx_ready);
    cover property (data_mode && urc_event);
endmodule // modem_props
bind modem_data_ctrl modem_props u_modem_props (.*);

// ---- dv/ppp_sink.sv ----
// sink model: ppp engine taking payload bytes, stalls on request
// assumes the controller holds payload_valid until ready
`timescale 1ns/1ns
module ppp_sink (
    input  logic       clk, rst_n, stall, payload_valid,
    input  logic [7:0] payload_data,
    output logic       payload_ready,
    output logic [7:0] last_byte,
    output int         got
);
    assign payload_ready = !stall;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) got <= 0;
        else if (payload_valid && payload_ready) begin
            last_byte <= payload_data;
            got <= got + 1;
        end
    end
endmodule // ppp_sink

// ---- dv/tb.sv ----
// testbench: data-mode controller with a stalling payload sink
// assumes short guard and hang-up counts set through parameters
`timescale 1ns/1ns
`include "modem_ctrl_defines.vh"
module tb;
    localparam int G = 20;
    logic       clk = 0, rst_n = 0, rx_valid = 0, cmd_valid = 0, stall = 0;
    logic       hangup_done = 0, urc_event = 0, rsp_valid, urc_send, ring;
    logic       payload_valid, payload_ready, data_mode, session_open;
    logic       urc_ring_indicator, rx_ready;
    logic [7:0] rx_byte = 0, payload_data, last_byte;
    logic [2:0] cmd_code = 0, rsp_code;
    int         miscompares = 0, checks_done = 0, cycles = 0, got;
    modem_data_ctrl #(
        .GUARD_CYCLES  (G),
        .HANGUP_CYCLES (50)
    ) u_modem_data_ctrl (
        .clk                (clk),
        .rst_n              (rst_n),
        .rx_byte            (rx_byte),
        .rx_valid           (rx_valid),
        .cmd_code           (cmd_code),
        .cmd_valid          (cmd_valid),
        .hangup_done        (hangup_done),
        .urc_event          (urc_event),
        .payload_data       (payload_data),
        .payload_valid      (payload_valid),
        .payload_ready      (payload_ready),
        .rsp_code           (rsp_code),
        .rsp_valid          (rsp_valid),
        .urc_send           (urc_send),
        .data_mode          (data_mode),
        .session_open       (session_open),
        .urc_ring_indicator (urc_ring_indicator),
        .rx_ready           (rx_ready)
    );
    ppp_sink u_ppp_sink (
        .clk           (clk),
        .rst_n         (rst_n),
        .stall         (stall),
        .payload_valid (payload_valid),
        .payload_data  (payload_data),
        .payload_ready (payload_ready),
        .last_byte     (last_byte),
        .got           (got)
    );
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic answer(input logic [2:0] e, input int n);
        for (int i = 0; i < n && rsp_valid !== 1'b1; i++) @(posedge clk) #1;
        chk(rsp_valid, n > 0);
        if (n > 0) chk(rsp_code, e);
    endtask
    task automatic cmd(input logic [2:0] c, e, input int n);
        @(posedge clk) cmd_code <= c;
        cmd_valid <= 1'b1;
        @(posedge clk) cmd_valid <= 1'b0;
        #1 answer(e, n);
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk) rx_byte <= b;
        rx_valid <= 1'b1;
        @(posedge clk) rx_valid <= 1'b0;
    endtask
    task automatic escape();
        repeat (G + 2) @(posedge clk);
        repeat (3) send(`CH_PLUS);
        repeat (G - 2) @(posedge clk);
        #1 chk(data_mode, 1);
        answer(`RSP_OK, 10);
        chk(data_mode, 0);
        chk(session_open, 1);
    endtask
    task automatic s_connect();
        @(posedge clk) urc_event <= 1'b1;
        @(posedge clk) urc_event <= 1'b0;
        #1 chk(urc_send, 1);
        cmd(`CMD_OTHER, `RSP_OK, 2);
        cmd(`CMD_ONLINE, `RSP_ERROR, 2);
        cmd(`CMD_DATA, `RSP_CONNECT, 2);
        cmd(`CMD_OTHER, 0, 0);
    endtask
    task automatic s_stream();
        send(8'h41);
        repeat (3) send(`CH_PLUS);
        repeat (G + 2) @(posedge clk);
        repeat (3) send(`CH_PLUS);
        send(8'h42);
        repeat (G + 5) @(posedge clk);
        #1 chk(data_mode, 1);
        chk(last_byte, 8'h42);
        chk(got[7:0], 8'h08);
        @(posedge clk) stall <= 1'b1;
        repeat (4) send(8'h5a);
        #1 chk(rx_ready, 0);
        @(posedge clk) stall <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(rx_ready, 1);
        chk(got[7:0], 8'h0a);
    endtask
    task automatic s_ring();
        ring = ~urc_ring_indicator;
        @(posedge clk) urc_event <= 1'b1;
        @(posedge clk) urc_event <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(urc_ring_indicator, ring);
        escape();
        @(posedge clk) #1 chk(urc_send, 1);
        cmd(`CMD_ONLINE, `RSP_CONNECT, 2);
    endtask
    task automatic s_hangup();
        escape();
        cmd(`CMD_HANGUP, `RSP_OK, 60);
        chk(session_open, 0);
        cmd(`CMD_DIAL, `RSP_CONNECT, 2);
        escape();
        @(posedge clk) cmd_code <= `CMD_HANGUP;
        cmd_valid <= 1'b1;
        @(posedge clk) cmd_valid <= 1'b0;
        hangup_done <= 1'b1;
        @(posedge clk) hangup_done <= 1'b0;
        #1 answer(`RSP_OK, 1);
        chk(session_open, 0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        s_connect();
        s_stream();
        s_ring();
        s_hangup();
        report_and_stop();
    end
endmodule // tb
